// ### dv/sfd_assertions.sv
// Port-level assertions for the serial queue sequencer
`timescale 1ns/1ps
module sfd_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclk,
    input wire logic        sdo,
    input wire logic        tx_dma_req,
    input wire logic        tx_dma_ack,
    input wire logic        rx_dma_req,
    input wire logic        rx_dma_ack
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase decode
    wire logic acc = psel && penable;
    wire logic rd  = acc && !pwrite;
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmap_err: assert property (acc && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_map_ok: assert property (acc && paddr <= 8'h1c |-> !pslverr)
        else $error("mapped access refused");
    a_fill_max: assert property (rd && paddr == 8'h1c |-> prdata <= 32'h8)
        else $error("fill count above depth");
    a_trg_field: assert property (rd && paddr == 8'h08 |-> (prdata & ~32'h707) == 32'h0)
        else $error("stop count reserved bits set");
    a_win_width: assert property (rd && paddr == 8'h18 |-> prdata[31:16] == 16'h0)
        else $error("receive window upper bits set");
    a_sclk_low: assert property ($fell(sclk) |=> !sclk)
        else $error("serial clock low phase too short");
    a_sclk_rise: assert property (!sclk |-> ##[1:16] sclk)
        else $error("serial clock stuck low");
    a_sdo_edge: assert property ($changed(sdo) |-> $fell(sclk) || sclk && $stable(sclk))
        else $error("data out moved off the falling edge");
    a_rxreq_hold: assert property (rx_dma_req && !rx_dma_ack |=> rx_dma_req)
        else $error("receive request dropped without pop");
    c_tx_dma: cover property (tx_dma_req && tx_dma_ack);
    c_rx_dma: cover property (rx_dma_req && rx_dma_ack);
    c_sclk: cover property ($fell(sclk));
endmodule // sfd_assertions

bind sfd_top sfd_assertions u_sfd_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .sdo(sdo), .tx_dma_req(tx_dma_req), .tx_dma_ack(tx_dma_ack),
    .rx_dma_req(rx_dma_req), .rx_dma_ack(rx_dma_ack));

// ### dv/sfd_peer.sv
// Serial peripheral model: sends a known word stream and captures data out
`timescale 1ns/1ps
module sfd_peer (
    input  wire logic        presetn,
    input  wire logic        sclk,
    input  wire logic        sdo,
    output logic             sdi,
    output logic [15:0]      got,
    output int               n
);
    logic [15:0] w;
    logic [15:0] sh;
    int          b;
    assign w = 16'h5a00 + n[15:0];
    initial begin
        sdi = 1'b1;
        n = 0;
        b = 0;
    end
    // Next bit MSB first on the falling edge
    always @(negedge sclk) if (presetn) sdi <= w[15-b];
    // Capture data out on the rising edge; line flips once the word is over
    always @(posedge sclk) if (presetn) begin
        sh = {sh[14:0], sdo};
        b++;
        if (b == 16) begin
            got = sh;
            b = 0;
            sdi <= ~sdi;
            n++;
        end
    end
endmodule // sfd_peer

// ### dv/tb.sv
// Self-checking bench for the serial queue sequencer
`timescale 1ns/1ps
`include "sfd_regs.svh"
module tb;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dma_on = 1'b0;
    logic        tx_dma_ack = 1'b0, rx_dma_ack = 1'b0, pready, pslverr, tx_dma_req, rx_dma_req, sclk, sdo, sdi;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'hbc3a7311;
    logic [15:0] tx_dma_data = 16'h0, rx_dma_data, got;
    logic [1:0]  rx_page_end = 2'h0;
    logic [31:0] exp_rd[$], exp_tx[$], exp_dma[$], tx_src[$];
    int          num_errors = 0, cmp_count = 0, pn, base;
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    sfd_top #(.HALF(4)) u_sfd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_dma_req(tx_dma_req), .tx_dma_ack(tx_dma_ack), .tx_dma_data(tx_dma_data), .rx_dma_req(rx_dma_req),
        .rx_dma_ack(rx_dma_ack), .rx_dma_data(rx_dma_data), .tx_page_end(rx_page_end), .rx_page_end(rx_page_end),
        .sclk(sclk), .sdo(sdo), .sdi(sdi));
    sfd_peer u_sfd_peer (.presetn(presetn), .sclk(sclk), .sdo(sdo), .sdi(sdi), .got(got), .n(pn));
    // ----------------------------------------
    // Compare, bus and helper tasks
    // ----------------------------------------
    task automatic cmp(input logic [31:0] a, input logic [31:0] e);
        cmp_count++;
        if (a !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [31:0] pw(input int k);
        return {16'h0, 16'h5a00 + k[15:0]};
    endfunction
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic wait_pn(input int k);
        for (int i = 0; i < 4000 && pn < k; i++) @(posedge pclk);
        repeat (300) @(posedge pclk);
        cmp(pn, k);
    endtask
    task automatic fresh(input logic [31:0] mode);
        wr(`SFD_CTRL_OFS, 32'h1);
        wr(`SFD_EVT_OFS, 32'h7f);
        wr(`SFD_MODE_OFS, mode);
        base = pn;
    endtask
    task automatic complete_run;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Result watchers and DMA partner side
    always @(pn) if (exp_tx.size() > 0) cmp({16'h0, got}, exp_tx.pop_front());
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) cmp(prdata, exp_rd.pop_front());
        if (rx_dma_req && rx_dma_ack && exp_dma.size() > 0) cmp({16'h0, rx_dma_data}, exp_dma.pop_front());
        if (tx_dma_req && tx_dma_ack) void'(tx_src.pop_front());
        rx_dma_ack <= rx_dma_req && dma_on;
        tx_dma_ack <= tx_dma_req && !tx_dma_ack && tx_src.size() > 0;
        tx_dma_data <= tx_src.size() > 0 ? tx_src[0][15:0] : ~tx_dma_data;
    end
    initial begin
        #2000000;
        num_errors++;
        complete_run;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) rd(a[7:0], 32'h0);
        rd(8'h20, 32'h0);
        wr(`SFD_TRG_OFS, 32'hffffffff);
        rd(`SFD_TRG_OFS, 32'h707);
        wr(`SFD_TRG_OFS, 32'h100);
        fresh(32'h7);
        wr(`SFD_CTRL_OFS, 32'he);
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            if (i < 2) exp_tx.push_back({16'h0, lfsr[15:0]});
            wr(`SFD_TXWIN_OFS, lfsr);
        end
        rd(`SFD_MODE_OFS, 32'hf);
        wait_pn(base + 2);
        rd(`SFD_EVT_OFS, 32'h5);
        rd(`SFD_FILL_OFS, 32'h2);
        for (int k = 0; k < 2; k++) rd(`SFD_RXWIN_OFS, pw(base + k));
        wr(`SFD_TRG_OFS, 32'h0);
        fresh(32'h7);
        for (int i = 0; i < 2; i++) begin
            lfsr = nxt(lfsr);
            tx_src.push_back(lfsr);
            exp_tx.push_back({16'h0, lfsr[15:0]});
        end
        wr(`SFD_CTRL_OFS, 32'h2a);
        wait_pn(base + 1);
        rd(`SFD_EVT_OFS, 32'h5);
        wr(`SFD_EVT_OFS, 32'h4);
        wait_pn(base + 2);
        fresh(32'h5);
        exp_dma = {pw(base), pw(base + 1)};
        dma_on = 1'b1;
        wr(`SFD_CTRL_OFS, 32'h44);
        rd(`SFD_RXBUF_OFS, pw(base - 1));
        for (int i = 0; i < 4000 && pn < base + 2; i++) @(posedge pclk);
        rx_page_end <= 2'h1;
        @(posedge pclk);
        rx_page_end <= 2'h0;
        repeat (300) @(posedge pclk);
        rd(`SFD_EVT_OFS, 32'h9);
        base = pn;
        wr(`SFD_EVT_OFS, 32'h7f);
        wait_pn(base);
        rd(`SFD_FILL_OFS, 32'h0);
        dma_on = 1'b0;
        wr(`SFD_TRG_OFS, 32'h2);
        fresh(32'h5);
        wr(`SFD_CTRL_OFS, 32'h14);
        rd(`SFD_RXBUF_OFS, pw(base - 1));
        wait_pn(base + 3);
        rd(`SFD_EVT_OFS, 32'h3);
        for (int k = 0; k < 3; k++) rd(`SFD_RXWIN_OFS, pw(base + k));
        fresh(32'h5);
        wr(`SFD_CTRL_OFS, 32'h4);
        rd(`SFD_RXBUF_OFS, pw(base - 1));
        wait_pn(base + 8);
        rd(`SFD_FILL_OFS, 32'h8);
        fresh(32'h7);
        wr(`SFD_CTRL_OFS, 32'h0);
        wr(`SFD_TXWIN_OFS, lfsr);
        wait_pn(base);
        complete_run;
    end
endmodule // tb

// ### inc/sfd_pkg.sv
// Types shared by the serial queue sequencer modules
package sfd_pkg;
    typedef enum logic [1:0] {SFD_IDLE, SFD_RUN, SFD_STOP} sfd_seq_e_t;

    // Command from the sequencer to the shift engine
    typedef struct packed {
        logic        start;
        logic        wide;
        logic [15:0] txd;
    } sfd_shift_cmd_t;

    // Shift engine state
    typedef struct packed {
        logic        busy;
        logic        done;
        logic        sclk;
        logic        sdo;
        logic        wide;
        logic [15:0] sh;
        logic [4:0]  bits;
        logic [7:0]  div;
        logic [1:0]  sync;
    } sfd_shift_t;

    // Sequencer and register state
    typedef struct packed {
        logic [6:0]  ctrl;
        logic [2:0]  mode;
        logic [2:0]  rx_trg;
        logic [2:0]  tx_trg;
        logic [6:0]  ev;
        sfd_seq_e_t  seq;
        logic [4:0]  cnt;
        logic [31:0] rdata;
    } sfd_state_t;
endpackage

// ### inc/sfd_regs.svh
// Register offsets, field positions and reset values of the serial queue sequencer
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SFD_CTRL_OFS   8'h00
`define SFD_MODE_OFS   8'h04
`define SFD_TRG_OFS    8'h08
`define SFD_EVT_OFS    8'h0c
`define SFD_RXBUF_OFS  8'h10
`define SFD_TXWIN_OFS  8'h14
`define SFD_RXWIN_OFS  8'h18
`define SFD_FILL_OFS   8'h1c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFD_C_RST      0
`define SFD_C_TXQ      1
`define SFD_C_RXQ      2
`define SFD_C_TXSE     3
`define SFD_C_RXSE     4
`define SFD_C_TXDMA    5
`define SFD_C_RXDMA    6
`define SFD_M_EN       0
`define SFD_M_DIR      1
`define SFD_M_WIDE     2
`define SFD_M_ACT      3
`define SFD_TRG_RX     2:0
`define SFD_TRG_TX     10:8
`define SFD_E_ITEM     0
`define SFD_E_RXCNT    1
`define SFD_E_TXCNT    2
`define SFD_E_RXP1     3
`define SFD_E_RXP2     4
`define SFD_E_TXP1     5
`define SFD_E_TXP2     6
// ----------------------------------------
// Reset values and serial constants
// ----------------------------------------
`define SFD_CTRL_RST   7'h00
`define SFD_MODE_RST   3'h0
`define SFD_TRG_RST    3'h0
`define SFD_EVT_RST    7'h00
`define SFD_WORD_BITS  5'h10
`define SFD_BYTE_BITS  5'h08
`define SFD_SCLK_HALF  8
`endif

// ### src/sfd_fifo.sv
// Word queue with registered head output
`timescale 1ns/1ps
module sfd_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          clear,
    input  wire logic          push,
    input  wire logic [W-1:0]  wdata,
    input  wire logic          pop,
    output logic      [W-1:0]  rdata,
    output logic      [AW:0]   count,
    output logic               full,
    output logic               empty
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW-1:0] next_rptr;
    logic          do_push;
    logic          do_pop;

    // Full and empty flags
    assign full      = (count == (AW+1)'(DEPTH));
    assign empty     = (count == '0);
    assign do_push   = push && !full;
    assign do_pop    = pop && !empty;
    assign next_rptr = do_pop ? rptr + 1'b1 : rptr;

    // Storage array
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wptr] <= wdata;
        end
    end

    // Pointers, fill level and head register; head bypasses a write into the head slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
            rdata <= '0;
        end else if (clear) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= do_push ? wptr + 1'b1 : wptr;
            rptr  <= next_rptr;
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
            rdata <= (do_push && wptr == next_rptr) ? wdata : mem[next_rptr];
        end
    end
endmodule // sfd_fifo

// ### src/sfd_shifter.sv
// Serial shift engine: serial clock and one 8 or 16 bit item, MSB first
`timescale 1ns/1ps
`include "sfd_regs.svh"
module sfd_shifter
    import sfd_pkg::*;
#(
    parameter int HALF = `SFD_SCLK_HALF
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  sfd_shift_cmd_t      cmd,
    input  wire logic           sdi,
    output logic                sclk,
    output logic                sdo,
    output logic                busy,
    output logic                done,
    output logic [15:0]         rxd
);
    sfd_shift_t s;
    sfd_shift_t next_s;

    // Clock divider, shift and sample
    always_comb begin
        next_s         = s;
        next_s.done    = 1'b0;
        next_s.sync[0] = sdi;
        next_s.sync[1] = s.sync[0];
        if (!s.busy) begin
            if (cmd.start) begin
                next_s.busy = 1'b1;
                next_s.wide = cmd.wide;
                next_s.sh   = cmd.wide ? cmd.txd : {cmd.txd[7:0], 8'h00};
                next_s.bits = cmd.wide ? `SFD_WORD_BITS : `SFD_BYTE_BITS;
                next_s.sdo  = cmd.wide ? cmd.txd[15] : cmd.txd[7];
                next_s.div  = '0;
            end
        end else if (s.div == 8'(HALF - 1)) begin
            next_s.div  = '0;
            next_s.sclk = ~s.sclk;
            if (!s.sclk) begin
                // Rising edge: sample the peripheral's bit
                next_s.sh   = {s.sh[14:0], s.sync[1]};
                next_s.bits = s.bits - 5'h01;
                if (s.bits == 5'h01) begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
            end else begin
                // Falling edge: present the next bit
                next_s.sdo = s.sh[15];
            end
        end else begin
            next_s.div = s.div + 8'h01;
        end
    end

    // State register; serial clock idles high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s      <= '0;
            s.sclk <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sclk = s.sclk;
    assign sdo  = s.sdo;
    assign busy = s.busy;
    assign done = s.done;
    assign rxd  = s.wide ? s.sh : {8'h00, s.sh[7:0]};
endmodule // sfd_shifter

// ### src/sfd_top.sv
// Sequential transfer control for the queued serial interface, with APB registers
// Functional notes
// - Queues work only when enabled; DMA requests only while the queue path is used.
// - Receive-only without DMA starts when software reads the receive buffer register.
// - Count stop off: receive continues while the receive queue has room.
// - Received words leave the receive window in arrival order.
// - Count stop on: receiving halts after the count, receive count flag set.
// - Each received item raises the item done flag.
// - Transmit-receive without DMA starts on a write to the transmit window.
// - Transfer active status rises as a queued transfer begins.
// - Count stop off: transmit continues while the transmit queue holds data and an enabled receive queue has room.
// - Count stop on: transmitting halts after the count, transmit count flag set.
// - Each transmitted item raises the item done flag.
// - DMA receive runs while room remains and no page end; words go to DMA.
// - A receive page end stops receiving and sets the page stop flag.
// - Clearing a stopping flag never resumes reception by itself.
// - Unit out of reset, enabled, queue and DMA on: fetch and transmit.
// - Writing one to the transmit count flag clears it and resumes DMA transmit.
// - A transmit page end stops sending and sets the page stop flag.
// - Stop count fields code one to eight sixteen-bit units.
// - Each receive window read of a non-empty receive queue advances the receive read pointer.
// - Transmit window writes push only while the transmit queue is enabled.
`timescale 1ns/1ps
`include "sfd_regs.svh"
module sfd_top
    import sfd_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int HALF  = `SFD_SCLK_HALF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             tx_dma_req,
    input  wire logic        tx_dma_ack,
    input  wire logic [15:0] tx_dma_data,
    output logic             rx_dma_req,
    input  wire logic        rx_dma_ack,
    output logic      [15:0] rx_dma_data,
    input  wire logic [1:0]  tx_page_end,
    input  wire logic [1:0]  rx_page_end,
    output logic             sclk,
    output logic             sdo,
    input  wire logic        sdi
);
    localparam int AW = $clog2(DEPTH);

    sfd_state_t     s;
    sfd_state_t     next_s;
    sfd_shift_cmd_t sh_cmd;
    logic           sh_busy;
    logic           sh_done;
    logic [15:0]    sh_rxd;
    logic           txq_push;
    logic [15:0]    txq_wdata;
    logic           txq_pop;
    logic [15:0]    txq_head;
    logic [AW:0]    txq_count;
    logic           txq_full;
    logic           txq_empty;
    logic           rxq_push;
    logic           rxq_pop;
    logic [15:0]    rxq_head;
    logic [AW:0]    rxq_count;
    logic           rxq_full;
    logic           rxq_empty;
    logic           setup;
    logic           wr_acc;
    logic           rd_acc;
    logic           mapped;
    logic           unit_rst;
    logic           tx_dir;
    logic           go;
    logic [6:0]     ev_set;
    logic [6:0]     ev_clr;
    logic [4:0]     next_cnt;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Item count at which a count stop fires; a byte item is half a unit
    function automatic logic [4:0] stop_limit(input logic [2:0] trg, input logic wide);
        logic [4:0] units;
        units = {2'b00, trg} + 5'h01;
        return wide ? units : {units[3:0], 1'b0};
    endfunction

    // Address decode
    function automatic logic is_mapped(input logic [7:0] a);
        return a == `SFD_CTRL_OFS || a == `SFD_MODE_OFS || a == `SFD_TRG_OFS ||
               a == `SFD_EVT_OFS || a == `SFD_RXBUF_OFS || a == `SFD_TXWIN_OFS ||
               a == `SFD_RXWIN_OFS || a == `SFD_FILL_OFS;
    endfunction

    // ----------------------------------------
    // APB decode
    // ----------------------------------------

    // Setup phase latches read data, access phase commits effects
    assign setup    = psel && !penable;
    assign mapped   = is_mapped(paddr);
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign rd_acc   = psel && penable && !pwrite && mapped;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = s.rdata;
    assign unit_rst = s.ctrl[`SFD_C_RST];
    assign tx_dir   = s.mode[`SFD_M_DIR];

    // ----------------------------------------
    // Queues and DMA handshakes
    // ----------------------------------------

    // Transmit queue filled by DMA or by window writes
    assign tx_dma_req = s.ctrl[`SFD_C_TXDMA] && s.ctrl[`SFD_C_TXQ] && !txq_full
                        && !unit_rst && s.mode[`SFD_M_EN];
    assign txq_push   = (tx_dma_req && tx_dma_ack) ||
                        (wr_acc && paddr == `SFD_TXWIN_OFS && s.ctrl[`SFD_C_TXQ]);
    assign txq_wdata  = (tx_dma_req && tx_dma_ack) ? tx_dma_data : pwdata[15:0];

    // Receive queue drained by DMA or by window reads
    assign rx_dma_req  = s.ctrl[`SFD_C_RXDMA] && s.ctrl[`SFD_C_RXQ] && !rxq_empty
                         && !unit_rst;
    assign rx_dma_data = rxq_head;
    assign rxq_pop     = (rx_dma_req && rx_dma_ack) ||
                         (rd_acc && paddr == `SFD_RXWIN_OFS);
    assign rxq_push    = sh_done && s.ctrl[`SFD_C_RXQ];

    sfd_fifo #(
        .W     (16),
        .DEPTH (DEPTH)
    ) u_txq (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (unit_rst),
        .push    (txq_push),
        .wdata   (txq_wdata),
        .pop     (txq_pop),
        .rdata   (txq_head),
        .count   (txq_count),
        .full    (txq_full),
        .empty   (txq_empty)
    );

    sfd_fifo #(
        .W     (16),
        .DEPTH (DEPTH)
    ) u_rxq (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (unit_rst),
        .push    (rxq_push),
        .wdata   (sh_rxd),
        .pop     (rxq_pop),
        .rdata   (rxq_head),
        .count   (rxq_count),
        .full    (rxq_full),
        .empty   (rxq_empty)
    );

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------

    // Next item may start once the engine is free and the queues allow it
    always_comb begin
        go = 1'b0;
        if (s.seq == SFD_RUN && !sh_busy && !sh_done && !unit_rst) begin
            if (tx_dir) begin
                go = !txq_empty && !(s.ctrl[`SFD_C_RXQ] && rxq_full);
            end else begin
                go = s.ctrl[`SFD_C_RXQ] && !rxq_full;
            end
        end
    end

    assign txq_pop      = go && tx_dir;
    assign sh_cmd.start = go;
    assign sh_cmd.wide  = s.mode[`SFD_M_WIDE];
    assign sh_cmd.txd   = tx_dir ? txq_head : 16'h0000;

    sfd_shifter #(
        .HALF (HALF)
    ) u_shift (
        .pclk    (pclk),
        .presetn (presetn),
        .cmd     (sh_cmd),
        .sdi     (sdi),
        .sclk    (sclk),
        .sdo     (sdo),
        .busy    (sh_busy),
        .done    (sh_done),
        .rxd     (sh_rxd)
    );

    // ----------------------------------------
    // Sequencer and registers
    // ----------------------------------------

    // Event flags: hardware set wins over a software clear
    always_comb begin
        ev_set   = '0;
        next_cnt = s.cnt + 5'h01;
        if (sh_done) begin
            ev_set[`SFD_E_ITEM] = 1'b1;
            if (tx_dir && s.ctrl[`SFD_C_TXSE] &&
                next_cnt == stop_limit(s.tx_trg, s.mode[`SFD_M_WIDE])) begin
                ev_set[`SFD_E_TXCNT] = 1'b1;
            end
            if (!tx_dir && s.ctrl[`SFD_C_RXSE] &&
                next_cnt == stop_limit(s.rx_trg, s.mode[`SFD_M_WIDE])) begin
                ev_set[`SFD_E_RXCNT] = 1'b1;
            end
        end
        if (s.seq == SFD_RUN && !tx_dir && s.ctrl[`SFD_C_RXDMA]) begin
            ev_set[`SFD_E_RXP1] = rx_page_end[0];
            ev_set[`SFD_E_RXP2] = rx_page_end[1];
        end
        if (s.seq == SFD_RUN && tx_dir && s.ctrl[`SFD_C_TXDMA]) begin
            ev_set[`SFD_E_TXP1] = tx_page_end[0];
            ev_set[`SFD_E_TXP2] = tx_page_end[1];
        end
        ev_clr = (wr_acc && paddr == `SFD_EVT_OFS) ? pwdata[6:0] : 7'h00;
    end

    // Register writes, read data capture and sequencing
    always_comb begin
        next_s    = s;
        next_s.ev = (s.ev & ~ev_clr) | ev_set;
        // Read data captured in the setup phase
        if (setup) begin
            case (paddr)
                `SFD_CTRL_OFS:  next_s.rdata = 32'(s.ctrl);
                `SFD_MODE_OFS:  next_s.rdata = 32'({s.seq == SFD_RUN || sh_busy, s.mode});
                `SFD_TRG_OFS:   next_s.rdata = 32'({5'h00, s.tx_trg, 5'h00, s.rx_trg});
                `SFD_EVT_OFS:   next_s.rdata = 32'(s.ev);
                `SFD_RXBUF_OFS: next_s.rdata = 32'(sh_rxd);
                `SFD_RXWIN_OFS: next_s.rdata = 32'(rxq_head);
                `SFD_FILL_OFS:  next_s.rdata = 32'(rxq_count);
                default:        next_s.rdata = 32'h0000_0000;
            endcase
        end
        // Configuration writes
        if (wr_acc) begin
            case (paddr)
                `SFD_CTRL_OFS: next_s.ctrl = pwdata[6:0];
                `SFD_MODE_OFS: next_s.mode = pwdata[2:0];
                `SFD_TRG_OFS: begin
                    next_s.rx_trg = pwdata[`SFD_TRG_RX];
                    next_s.tx_trg = pwdata[`SFD_TRG_TX];
                end
                default: ;
            endcase
        end
        // Item counter
        if (go && s.seq == SFD_RUN && sh_done) begin
            next_s.cnt = s.cnt;
        end else if (sh_done) begin
            next_s.cnt = next_cnt;
        end
        // Transfer sequence
        case (s.seq)
            SFD_IDLE: begin
                if (!tx_dir && rd_acc && paddr == `SFD_RXBUF_OFS && s.ctrl[`SFD_C_RXQ]
                    && s.mode[`SFD_M_EN]) begin
                    next_s.seq = SFD_RUN;
                    next_s.cnt = '0;
                end else if (tx_dir && txq_push && s.ctrl[`SFD_C_TXQ] && s.mode[`SFD_M_EN]) begin
                    next_s.seq = SFD_RUN;
                    next_s.cnt = '0;
                end else if (tx_dir && s.ctrl[`SFD_C_TXDMA] && s.ctrl[`SFD_C_TXQ]
                             && s.mode[`SFD_M_EN] && !txq_empty) begin
                    next_s.seq = SFD_RUN;
                    next_s.cnt = '0;
                end
            end
            SFD_RUN: begin
                if (|ev_set[6:1]) begin
                    // Count stop or page end halts the stream
                    next_s.seq = SFD_STOP;
                end else if (tx_dir && !sh_busy && !sh_done && txq_empty
                             && !s.ctrl[`SFD_C_TXDMA]) begin
                    next_s.seq = SFD_IDLE;
                end
            end
            SFD_STOP: begin
                // Only a fresh start leaves the stop, or with transmit DMA on a transmit count flag clear
                if (!tx_dir && rd_acc && paddr == `SFD_RXBUF_OFS) begin
                    next_s.seq = SFD_RUN;
                    next_s.cnt = '0;
                end else if (tx_dir && s.ctrl[`SFD_C_TXDMA] && s.ev[`SFD_E_TXCNT]
                             && ev_clr[`SFD_E_TXCNT]) begin
                    next_s.seq = SFD_RUN;
                    next_s.cnt = '0;
                end else if (tx_dir && !s.ctrl[`SFD_C_TXDMA] && txq_push) begin
                    next_s.seq = SFD_RUN;
                    next_s.cnt = '0;
                end
            end
            default: next_s.seq = SFD_IDLE;
        endcase
        // Unit reset returns the sequencer to idle and clears the item count
        if (unit_rst) begin
            next_s.seq = SFD_IDLE;
            next_s.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s        <= '0;
            s.ctrl   <= `SFD_CTRL_RST;
            s.mode   <= `SFD_MODE_RST;
            s.rx_trg <= `SFD_TRG_RST;
            s.tx_trg <= `SFD_TRG_RST;
            s.ev     <= `SFD_EVT_RST;
            s.seq    <= SFD_IDLE;
        end else begin
            s <= next_s;
        end
    end
endmodule // sfd_top
